// ===== core/plm_regs.sv
// paged register map of a 144 led matrix driver
`timescale 1ns/10ps
`default_nettype none
module plm_regs #(
	parameter int FRAME_PAGES = plm_pkg::PLM_FRAME_PAGES
) (
	input  wire logic         clock,
	input  wire logic         reset,
	input  wire logic         addrValid,
	input  wire logic [7:0]   addrByte,
	input  wire logic         wrValid,
	input  wire logic [7:0]   wrByte,
	input  wire logic         rdReq,
	input  wire logic [7:0]   frameStatus,
	input  wire logic [10:0]  scanAddr,
	output logic              rdValid,
	output logic [7:0]        rdData,
	output logic [7:0]        scanData,
	output logic [7:0]        pageSelect,
	output logic [1:0]        displayMode,
	output logic [2:0]        startFrame,
	output logic              modeStatic,
	output logic              modeAuto,
	output logic              modeAudio,
	output logic              shutdownActive,
	output logic [103:0]      funcImage
);
	if (FRAME_PAGES < 1 || FRAME_PAGES > 2**plm_pkg::PLM_PAGE_W) begin : g_chk
		$error("FRAME_PAGES out of range");
	end

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [7:0]         ptr_q, ptr_d;
	logic [7:0]         page_q, page_d;
	logic [7:0]         func_q [plm_pkg::PLM_FUNC_COUNT];
	logic [7:0]         func_d [plm_pkg::PLM_FUNC_COUNT];
	logic               pend_q, pend_d;
	plm_pkg::plm_src_t  src_q, src_d;
	logic [3:0]         rofs_q, rofs_d;
	logic               rdValid_d;
	logic [7:0]         rdData_d;
	logic [1:0]         mode_d;
	logic [2:0]         start_d;
	logic               down_d;
	logic               frameSel;
	logic               funcSel;
	logic               memWe;
	logic               rdTake;
	logic               wrTake;

	plm_mem_if mi ();

	plm_frame_mem u_mem (
		.clock (clock),
		.m     (mi.mem)
	);

	assign frameSel = page_q < 8'(FRAME_PAGES);
	assign funcSel  = page_q == plm_pkg::PLM_FUNC_PAGE_CODE;
	assign wrTake   = wrValid && !addrValid;
	assign rdTake   = rdReq && !addrValid && !wrValid;

	// flat {page, offset} addressing gives every frame page its own 256 byte slot
	assign mi.hostAddr  = {page_q[2:0], ptr_q};
	assign mi.hostWdata = wrByte;
	assign mi.hostWe    = memWe;
	assign mi.scanAddr  = scanAddr;
	assign scanData     = mi.scanRdata;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		ptr_d  = ptr_q;
		page_d = page_q;
		func_d = func_q;
		func_d[plm_pkg::PLM_FSTATE_OFS[3:0]] = frameStatus;
		memWe  = 1'b0;
		pend_d = 1'b0;
		src_d  = src_q;
		rofs_d = rofs_q;
		if (addrValid) begin
			ptr_d = addrByte;
		end else if (wrValid) begin
			ptr_d = ptr_q + 8'h01;
			if (ptr_q == plm_pkg::PLM_PAGE_SELECT_OFS) begin
				page_d = wrByte;
			end else if (frameSel && plm_pkg::plm_in_frame(ptr_q)) begin
				memWe = 1'b1;
			end else if (funcSel && plm_pkg::plm_func_live(ptr_q)
				&& ptr_q != plm_pkg::PLM_FSTATE_OFS) begin
				func_d[ptr_q[3:0]] = wrByte;
			end
			// anything else is dropped
		end else if (rdReq) begin
			ptr_d  = ptr_q + 8'h01;
			pend_d = 1'b1;
			rofs_d = ptr_q[3:0];
			if (ptr_q == plm_pkg::PLM_PAGE_SELECT_OFS) begin
				src_d = plm_pkg::PLM_SRC_PAGE;
			end else if (frameSel && plm_pkg::plm_in_frame(ptr_q) && shutdownActive) begin
				src_d = plm_pkg::PLM_SRC_FRAME;
			end else if (funcSel && plm_pkg::plm_func_live(ptr_q)) begin
				src_d = plm_pkg::PLM_SRC_FUNC;
			end else begin
				src_d = plm_pkg::PLM_SRC_ZERO;
			end
		end
		rdValid_d = pend_q;
		rdData_d  = rdData;
		if (pend_q) begin
			unique case (src_q)
				plm_pkg::PLM_SRC_ZERO:  rdData_d = 8'h00;
				plm_pkg::PLM_SRC_FRAME: rdData_d = mi.hostRdata;
				plm_pkg::PLM_SRC_FUNC:  rdData_d = func_q[rofs_q];
				plm_pkg::PLM_SRC_PAGE:  rdData_d = page_q;
				default:                rdData_d = 8'h00;
			endcase
		end
		mode_d = func_d[plm_pkg::PLM_CFG_OFS[3:0]][plm_pkg::PLM_MODE_MSB:plm_pkg::PLM_MODE_LSB];
		start_d = func_d[plm_pkg::PLM_CFG_OFS[3:0]]
			[plm_pkg::PLM_START_MSB:plm_pkg::PLM_START_LSB];
		// run bit low means soft power down, so reset lands in shutdown
		down_d = !func_d[plm_pkg::PLM_PWRDN_OFS[3:0]][plm_pkg::PLM_RUN_BIT];
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (reset) begin
			ptr_q          <= 8'h00;
			page_q         <= plm_pkg::PLM_PAGE_SELECT_RESET;
			for (int i = 0; i < plm_pkg::PLM_FUNC_COUNT; i++) begin
				func_q[i] <= plm_pkg::PLM_FUNC_RESET;
			end
			pend_q         <= 1'b0;
			src_q          <= plm_pkg::PLM_SRC_ZERO;
			rofs_q         <= 4'h0;
			rdValid        <= 1'b0;
			rdData         <= 8'h00;
			pageSelect     <= plm_pkg::PLM_PAGE_SELECT_RESET;
			displayMode    <= 2'h0;
			startFrame     <= 3'h0;
			modeStatic     <= 1'b1;
			modeAuto       <= 1'b0;
			modeAudio      <= 1'b0;
			shutdownActive <= 1'b1;
		end else begin
			ptr_q          <= ptr_d;
			page_q         <= page_d;
			func_q         <= func_d;
			pend_q         <= pend_d;
			src_q          <= src_d;
			rofs_q         <= rofs_d;
			rdValid        <= rdValid_d;
			rdData         <= rdData_d;
			pageSelect     <= page_d;
			displayMode    <= mode_d;
			startFrame     <= start_d;
			modeStatic     <= mode_d == 2'h0;
			modeAuto       <= mode_d == 2'h1;
			modeAudio      <= mode_d[1];
			shutdownActive <= down_d;
		end
	end

	for (genvar g = 0; g < plm_pkg::PLM_FUNC_COUNT; g++) begin : g_img
		assign funcImage[g*8 +: 8] = func_q[g];
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	page_write_a: assert property (
		wrTake && ptr_q == plm_pkg::PLM_PAGE_SELECT_OFS |=> page_q == $past(wrByte)
	) else $error("page select not stored");

	func_page_a: assert property (
		funcSel |-> !memWe
	) else $error("frame memory written on function page");

	frame_write_a: assert property (
		wrTake && frameSel && ptr_q <= plm_pkg::PLM_FRAME_LAST |-> memWe
	) else $error("frame byte not written");

	ptr_step_a: assert property (
		wrTake |=> ptr_q == $past(ptr_q) + 8'h01
	) else $error("pointer did not advance");

	frame_gate_a: assert property (
		rdTake && frameSel && !shutdownActive && ptr_q <= plm_pkg::PLM_FRAME_LAST
		|-> ##2 rdValid && rdData == 8'h00
	) else $error("frame read outside shutdown");

	state_ro_a: assert property (
		wrTake && funcSel && ptr_q == plm_pkg::PLM_FSTATE_OFS
		|=> func_q[7] == $past(frameStatus)
	) else $error("frame state written by host");

	unused_rd_a: assert property (
		rdTake && funcSel && ptr_q == plm_pkg::PLM_UNUSED_OFS |-> ##2 rdData == 8'h00
	) else $error("unused slot read not zero");

	reserved_page_a: assert property (
		!frameSel && !funcSel |-> !memWe
	) else $error("write on reserved page");

	mode_onehot_a: assert property (
		$onehot({modeStatic, modeAuto, modeAudio})
	) else $error("mode decode not one hot");

	cfg_write_a: assert property (
		wrTake && funcSel && ptr_q == plm_pkg::PLM_CFG_OFS
		|=> displayMode == $past(wrByte[4:3]) && startFrame == $past(wrByte[2:0])
	) else $error("config fields not updated");

	sync_rw_a: assert property (
		wrTake && funcSel && ptr_q == plm_pkg::PLM_SYNC_OFS
		|=> func_q[6] == $past(wrByte)
	) else $error("audio sync not stored");

	read_lat_a: assert property (
		rdTake |-> ##2 rdValid
	) else $error("read answer latency wrong");

	// back to back reads keep rdValid high, so pair answers to requests
	read_pair_a: assert property (
		rdValid |-> $past(rdTake, 2)
	) else $error("read answer without request");

	ptr_load_a: assert property (
		addrValid |=> ptr_q == $past(addrByte)
	) else $error("pointer not loaded");

	rd_step_a: assert property (
		rdTake |=> ptr_q == $past(ptr_q) + 8'h01
	) else $error("pointer did not advance on read");

	page_hold_a: assert property (
		!(wrTake && ptr_q == plm_pkg::PLM_PAGE_SELECT_OFS) |=> page_q == $past(page_q)
	) else $error("page select changed without write");

	page_rd_a: assert property (
		rdTake && ptr_q == plm_pkg::PLM_PAGE_SELECT_OFS
		|-> ##2 rdData == $past(page_q)
	) else $error("page select read back wrong");

	reserved_rd_a: assert property (
		rdTake && !frameSel && !funcSel && ptr_q != plm_pkg::PLM_PAGE_SELECT_OFS
		|-> ##2 rdData == 8'h00
	) else $error("reserved page read not zero");

	frame_range_a: assert property (
		wrTake && frameSel && ptr_q > plm_pkg::PLM_FRAME_LAST |-> !memWe
	) else $error("write beyond frame page");

	func_write_a: assert property (
		wrTake && funcSel && plm_pkg::plm_func_live(ptr_q) && ptr_q != plm_pkg::PLM_FSTATE_OFS
		|=> func_q[$past(ptr_q[3:0])] == $past(wrByte)
	) else $error("function register not written");

	shutdown_bit_a: assert property (
		wrTake && funcSel && ptr_q == plm_pkg::PLM_PWRDN_OFS
		|=> shutdownActive == !$past(wrByte[plm_pkg::PLM_RUN_BIT])
	) else $error("shutdown control not applied");

	sync_rd_a: assert property (
		rdTake && funcSel && ptr_q == plm_pkg::PLM_SYNC_OFS
		|-> ##2 rdData == $past(func_q[6])
	) else $error("audio sync read back wrong");

	state_rd_a: assert property (
		rdTake && funcSel && ptr_q == plm_pkg::PLM_FSTATE_OFS
		|-> ##2 rdData == $past(func_q[7])
	) else $error("frame state read back wrong");

	state_track_a: assert property (
		!$past(reset) |-> func_q[7] == $past(frameStatus)
	) else $error("frame state not tracking");

endmodule : plm_regs
`default_nettype wire

// ===== common/plm_pkg.sv
// constants, types and decoders of the paged led matrix register map
package plm_pkg;

	localparam int PLM_PAGE_W = 3;
	localparam int PLM_OFS_W  = 8;
	localparam int PLM_MEM_AW = PLM_PAGE_W + PLM_OFS_W;
	localparam int PLM_FRAME_PAGES = 8;
	localparam int PLM_FUNC_COUNT  = 13;

	// ----------------------------------------
	// page select codes and offset
	// ----------------------------------------
	localparam logic [7:0] PLM_PAGE_SELECT_OFS   = 8'hfd;
	localparam logic [7:0] PLM_PAGE_SELECT_RESET = 8'h00;
	localparam logic [7:0] PLM_FUNC_PAGE_CODE    = 8'h0b;

	// ----------------------------------------
	// frame page layout
	// ----------------------------------------
	localparam logic [7:0] PLM_ONOFF_BASE = 8'h00;
	localparam logic [7:0] PLM_BLINK_BASE = 8'h12;
	localparam logic [7:0] PLM_DUTY_BASE  = 8'h24;
	localparam logic [7:0] PLM_FRAME_LAST = 8'hb3;

	// ----------------------------------------
	// function page offsets and fields
	// ----------------------------------------
	localparam logic [7:0] PLM_CFG_OFS     = 8'h00;
	localparam logic [7:0] PLM_STILL_OFS   = 8'h01;
	localparam logic [7:0] PLM_SEQCNT_OFS  = 8'h02;
	localparam logic [7:0] PLM_SEQDLY_OFS  = 8'h03;
	localparam logic [7:0] PLM_UNUSED_OFS  = 8'h04;
	localparam logic [7:0] PLM_DISPOPT_OFS = 8'h05;
	localparam logic [7:0] PLM_SYNC_OFS    = 8'h06;
	localparam logic [7:0] PLM_FSTATE_OFS  = 8'h07;
	localparam logic [7:0] PLM_FADET_OFS   = 8'h08;
	localparam logic [7:0] PLM_FADEC_OFS   = 8'h09;
	localparam logic [7:0] PLM_PWRDN_OFS   = 8'h0a;
	localparam logic [7:0] PLM_GAIN_OFS    = 8'h0b;
	localparam logic [7:0] PLM_RATE_OFS    = 8'h0c;
	localparam logic [7:0] PLM_FUNC_RESET  = 8'h00;
	localparam int PLM_MODE_MSB  = 4;
	localparam int PLM_MODE_LSB  = 3;
	localparam int PLM_START_MSB = 2;
	localparam int PLM_START_LSB = 0;
	localparam int PLM_RUN_BIT   = 0;

	typedef enum logic [3:0] {
		PLM_SRC_ZERO  = 4'b0001,
		PLM_SRC_FRAME = 4'b0010,
		PLM_SRC_FUNC  = 4'b0100,
		PLM_SRC_PAGE  = 4'b1000
	} plm_src_t;

	function automatic logic plm_in_frame(input logic [7:0] ofs);
		return ofs <= PLM_FRAME_LAST;
	endfunction : plm_in_frame

	// offset 04 takes no data and reads as zero; 07 is read only
	function automatic logic plm_func_live(input logic [7:0] ofs);
		return ofs <= PLM_RATE_OFS && ofs != PLM_UNUSED_OFS;
	endfunction : plm_func_live

endpackage : plm_pkg

// ===== common/plm_mem_if.sv
// carrier between the register map and its frame memory
`timescale 1ns/10ps
`default_nettype none
interface plm_mem_if;
	logic                       hostWe;
	logic [plm_pkg::PLM_MEM_AW-1:0] hostAddr;
	logic [7:0]                 hostWdata;
	logic [7:0]                 hostRdata;
	logic [plm_pkg::PLM_MEM_AW-1:0] scanAddr;
	logic [7:0]                 scanRdata;
	modport ctrl (output hostWe, hostAddr, hostWdata, scanAddr, input hostRdata, scanRdata);
	modport mem  (input hostWe, hostAddr, hostWdata, scanAddr, output hostRdata, scanRdata);
endinterface : plm_mem_if
`default_nettype wire

// ===== core/plm_frame_mem.sv
// frame page storage with a host port and a scan read port
`timescale 1ns/10ps
`default_nettype none
module plm_frame_mem (
	input  wire logic clock,
	plm_mem_if.mem    m
);
	logic [7:0] store [2**plm_pkg::PLM_MEM_AW];

	// no reset: frame contents are undefined until software loads them
	always_ff @(posedge clock) begin
		if (m.hostWe) begin
			store[m.hostAddr] <= m.hostWdata;
		end
		m.hostRdata <= store[m.hostAddr];
		m.scanRdata <= store[m.scanAddr];
	end
endmodule : plm_frame_mem
`default_nettype wire

// ===== testbench/plm_host_model.sv
// host model: issues register byte events and notes expected reads
`timescale 1ns/10ps
`default_nettype none
module plm_host_model (
	input  wire logic clock,
	output logic      addrValid,
	output logic [7:0] addrByte,
	output logic      wrValid,
	output logic [7:0] wrByte,
	output logic      rdReq
);
	logic [7:0] expQ[$];
	initial begin
		addrValid = 1'b0;
		wrValid = 1'b0;
		rdReq = 1'b0;
		addrByte = 8'h00;
		wrByte = 8'h00;
	end
	// all strobes re-driven each event, so events run back to back
	task automatic ev(input logic a, input logic w, input logic r, input logic [7:0] b);
		@(negedge clock);
		addrValid = a;
		wrValid = w;
		rdReq = r;
		// released bytes toggle so a stale value cannot pass
		addrByte = a ? b : ~addrByte;
		wrByte = w ? b : ~wrByte;
	endtask : ev
	task automatic seek(input logic [7:0] o);
		ev(1'b1, 1'b0, 1'b0, o);
	endtask : seek
	task automatic wr(input logic [7:0] b);
		ev(1'b0, 1'b1, 1'b0, b);
	endtask : wr
	task automatic rd(input logic [7:0] e);
		ev(1'b0, 1'b0, 1'b1, 8'h00);
		expQ.push_back(e);
	endtask : rd
	task automatic idle();
		ev(1'b0, 1'b0, 1'b0, 8'h00);
	endtask : idle
	task automatic page(input logic [7:0] p);
		seek(8'hfd);
		wr(p);
	endtask : page
endmodule : plm_host_model
`default_nettype wire

// ===== testbench/plm_regs_tb_top.sv
// self-checking bench of the paged register map
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((e) !== (g)) begin failures++; \
	$display("[ERR] %s exp %h got %h", nm, e, g); end end
module plm_regs_tb_top;
	logic clock = 1'b0;
	logic reset;
	logic [7:0] frameStatus, expV;
	logic [10:0] scanAddr;
	wire logic addrValid, wrValid, rdReq, rdValid;
	wire logic modeStatic, modeAuto, modeAudio, shutdownActive;
	wire logic [7:0] addrByte, wrByte, rdData, scanData, pageSelect;
	wire logic [1:0] displayMode;
	wire logic [2:0] startFrame;
	wire logic [103:0] funcImage;
	logic [7:0] fv[8][3];
	logic [7:0] fn[13];
	logic [7:0] ofsT[3] = '{8'h00, 8'h23, 8'hb3};
	int failures = 0;
	int num_checks = 0;
	always #25 clock = ~clock;
	plm_regs u_dut (.clock(clock), .reset(reset), .addrValid(addrValid), .addrByte(addrByte),
		.wrValid(wrValid), .wrByte(wrByte), .rdReq(rdReq), .frameStatus(frameStatus),
		.scanAddr(scanAddr), .rdValid(rdValid), .rdData(rdData), .scanData(scanData),
		.pageSelect(pageSelect), .displayMode(displayMode), .startFrame(startFrame),
		.modeStatic(modeStatic), .modeAuto(modeAuto), .modeAudio(modeAudio),
		.shutdownActive(shutdownActive), .funcImage(funcImage));
	plm_host_model u_host (.clock(clock), .addrValid(addrValid), .addrByte(addrByte),
		.wrValid(wrValid), .wrByte(wrByte), .rdReq(rdReq));
	task automatic close_out();
		if (failures == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : close_out
	// ----------------------------------------
	// read monitor
	// ----------------------------------------
	always @(posedge clock) begin
		if (rdValid === 1'b1) begin
			if (u_host.expQ.size() == 0) `CHK("spare rdValid", 1'b0, rdValid)
			else begin
				expV = u_host.expQ.pop_front();
				`CHK("rdData", expV, rdData)
			end
		end
	end
	initial begin
		#2000000;
		failures++;
		close_out();
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		reset = 1'b1;
		frameStatus = 8'h00;
		scanAddr = 11'h000;
		void'($urandom(32'h520fbc4b));
		repeat (12) @(negedge clock);
		`CHK("frame state", 8'h00, funcImage[63:56])
		reset = 1'b0;
		frameStatus = 8'($urandom);
		`CHK("pageSelect", 8'h00, pageSelect)
		`CHK("modeStatic", 1'b1, modeStatic)
		`CHK("shutdown", 1'b1, shutdownActive)
		`CHK("cfg", 8'h00, funcImage[7:0])
		`CHK("sync", 8'h00, funcImage[55:48])
		// frame data set up while still shut down
		for (int p = 0; p < 8; p++) begin
			u_host.page(8'(p));
			for (int k = 0; k < 3; k++) begin
				fv[p][k] = 8'($urandom);
				u_host.seek(ofsT[k]);
				u_host.wr(fv[p][k]);
			end
			u_host.wr(8'hff);
		end
		for (int p = 0; p < 8; p++) begin
			u_host.page(8'(p));
			for (int k = 0; k < 3; k++) begin
				u_host.seek(ofsT[k]);
				u_host.rd(fv[p][k]);
			end
			u_host.rd(8'h00);
			scanAddr = {3'(p), 8'h23};
			u_host.idle();
			`CHK("scanData", fv[p][1], scanData)
		end
		u_host.page(8'h08);
		u_host.seek(8'h00);
		u_host.wr(8'h5a);
		u_host.seek(8'h00);
		u_host.rd(8'h00);
		u_host.seek(8'hfd);
		u_host.rd(8'h08);
		u_host.page(8'h00);
		u_host.seek(8'h00);
		u_host.rd(fv[0][0]);
		u_host.page(8'h0b);
		u_host.idle();
		`CHK("pageSelect", 8'h0b, pageSelect)
		u_host.seek(8'h00);
		for (int g = 0; g < 13; g++) begin
			fn[g] = 8'($urandom);
			if (g == 10) fn[g][0] = 1'b0;
			u_host.wr(fn[g]);
		end
		u_host.idle();
		for (int g = 0; g < 13; g++)
			if (g != 4) `CHK("funcImage", (g == 7) ? frameStatus : fn[g], funcImage[g*8+:8])
		`CHK("displayMode", fn[0][4:3], displayMode)
		`CHK("startFrame", fn[0][2:0], startFrame)
		frameStatus = 8'($urandom);
		u_host.seek(8'h00);
		for (int g = 0; g < 13; g++)
			u_host.rd((g == 4) ? 8'h00 : (g == 7) ? frameStatus : fn[g]);
		for (int m = 0; m < 4; m++) begin
			u_host.seek(8'h00);
			u_host.wr({3'h0, 2'(m), 3'h5});
			u_host.idle();
			`CHK("modeStatic", m == 0, modeStatic)
			`CHK("modeAuto", m == 1, modeAuto)
			`CHK("modeAudio", m >= 2, modeAudio)
		end
		u_host.seek(8'h0a);
		u_host.wr(8'h01);
		u_host.idle();
		`CHK("shutdown", 1'b0, shutdownActive)
		u_host.page(8'h00);
		u_host.seek(8'h00);
		u_host.rd(8'h00);
		u_host.page(8'h0b);
		u_host.seek(8'h0a);
		u_host.rd(8'h01);
		repeat (4) u_host.idle();
		`CHK("pending reads", 0, u_host.expQ.size())
		// second reset mid-run must bring back the reset values of rdValid, page select, static mode, shutdown, cfg, sync and frame state
		reset = 1'b1;
		frameStatus = 8'($urandom);
		repeat (2) @(negedge clock);
		reset = 1'b0;
		`CHK("rdValid", 1'b0, rdValid)
		`CHK("pageSelect", 8'h00, pageSelect)
		`CHK("modeStatic", 1'b1, modeStatic)
		`CHK("shutdown", 1'b1, shutdownActive)
		`CHK("cfg", 8'h00, funcImage[7:0])
		`CHK("sync", 8'h00, funcImage[55:48])
		`CHK("frame state", 8'h00, funcImage[63:56])
		u_host.idle();
		`CHK("frame state", frameStatus, funcImage[63:56])
		close_out();
	end
endmodule : plm_regs_tb_top
`undef CHK
`default_nettype wire
